//--- hdl/nand_read_host_map.svh
// constants of the nand read host: commands, status bits, timing
`ifndef NAND_READ_HOST_MAP_SVH
`define NAND_READ_HOST_MAP_SVH

// command bytes
`define CMD_READ_SETUP    8'h00
`define CMD_READ_CONFIRM  8'h30
`define CMD_COL_SETUP     8'h05
`define CMD_COL_CONFIRM   8'he0
`define CMD_CACHE_NEXT    8'h31
`define CMD_CACHE_LAST    8'h3f
`define CMD_STATUS        8'h70

// status byte fields
`define SR_CACHE_READY_BIT 6
`define SR_ARRAY_IDLE_BIT  5

// address cycle counts
`define ADDR_CYC_SMALL    3'h4
`define ADDR_CYC_LARGE    3'h5
`define ADDR_CYC_COLUMN   3'h2

// page geometry
`define PAGE_BYTES_SMALL  13'h0880
`define PAGE_BYTES_LARGE  13'h1100
`define PAGES_PER_BLOCK   64

// timing, in ns, and the system clock rate in MHz
`define CLK_MHZ           100
`define STROBE_PHASE_NS   30
`define READ_CYCLE_NS     60
`define EDO_LIMIT_NS      30
`define BUSY_ONSET_NS     100

`endif

//--- hdl/nand_read_host_pkg.sv
// types of the nand read host: operations, densities, request and pin carriers
package nand_read_host_pkg;

  typedef enum logic [2:0] {
    OP_PAGE_READ  = 3'h0,
    OP_COL_CHANGE = 3'h1,
    OP_CACHE_SEQ  = 3'h2,
    OP_CACHE_RAND = 3'h3,
    OP_CACHE_LAST = 3'h4,
    OP_STATUS     = 3'h5,
    OP_RESUME     = 3'h6,
    OP_DATA_OUT   = 3'h7
  } op_e;

  typedef enum logic [1:0] {
    DENS_1G = 2'h0,
    DENS_2G = 2'h1,
    DENS_4G = 2'h2
  } density_e;

  typedef struct packed {
    op_e         op;
    density_e    density;
    logic [12:0] col;
    logic [16:0] row;
    logic [12:0] len;
  } req_s;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic [7:0] io_out;
    logic       io_oe_n;
  } pin_out_s;

endpackage

//--- hdl/nand_read_host.sv
// host controller issuing page and cache reads to a parallel nand flash
`timescale 1ns/1ps
`include "nand_read_host_map.svh"

// Function
// R1 - four address bytes 1Gb, five otherwise
// R2 - byte two holds A11..A8, top low
// R3 - rows A19..A12, A27..A20, A28 fifth
// R4 - 4Gb: A12..A8, A20..A13, A28..A21, A29
// R5 - device uses A18/A19 as plane select
// R6 - spare access zeroes next four column bits
// R7 - device page is 2176 or 4352 bytes
// R8 - device blocks hold 64 pages
// R9 - device preloads first page at power up
// R10 - page read is 00h, address, 30h
// R11 - wait for ready before reading data
// R12 - fast read cycles sample next falling edge
// R13 - 05h, column bytes, E0h moves output pointer
// R14 - sequential cache read issues 31h after ready
// R15 - device prefetches next page during output
// R16 - device cache read crosses block boundaries
// R17 - 3Fh marks the final cache page
// R18 - busy pin and status flags report readiness
// R19 - after 70h, 00h resumes data output
// R20 - random cache read: 00h, address, 31h
// R21 - device ignores column in random cache
// R22 - device accepts 05h-E0h in cache modes
// R23 - each read strobe fall advances column
// R24 - device latches byte on write strobe rise
// R25 - device holds ready/busy low while busy
module nand_read_host (
  // system
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // user request
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire nand_read_host_pkg::req_s  req,
  // read data and status
  output logic [7:0]                     rd_data,
  output logic                           rd_valid,
  output logic                           op_done,
  output logic                           cache_ready_flag,
  output logic                           array_idle_flag,
  // flash pins
  output nand_read_host_pkg::pin_out_s   pins,
  input  wire logic [7:0]                io_in,
  input  wire logic                      ready_busy
);
  import nand_read_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts
  localparam int STROBE_CYC_I = (`STROBE_PHASE_NS * `CLK_MHZ + 999) / 1000;
  localparam int BUSY_CYC_I   = (`BUSY_ONSET_NS * `CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STROBE_CYC = 4'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);
  localparam logic [5:0] BUSY_CYC   = 6'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);
  // short read cycles shift sampling to the next falling edge
  localparam logic EDO_MODE = (`READ_CYCLE_NS < `EDO_LIMIT_NS); // R12

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_CMD1     = 3'h1,
    ST_ADDR     = 3'h3,
    ST_CMD2     = 3'h2,
    ST_WAIT_WB  = 3'h6,
    ST_WAIT_RDY = 3'h7,
    ST_READ     = 3'h5,
    ST_DONE     = 3'h4
  } state_e;

  state_e      state_reg;
  state_e      state_next;
  req_s        req_reg;
  logic [3:0]  div_reg;
  logic        phase_reg;
  logic [12:0] byte_cnt_reg;
  logic [5:0]  wait_cnt_reg;
  logic        tick;
  logic        bus_state;
  logic        cycle_end;

  ////////////////////////////////////////////////////////////////////////////
  // operation decode
  logic       has_cmd1;
  logic [7:0] cmd1;
  logic [2:0] addr_cnt;
  logic       has_cmd2;
  logic [7:0] cmd2;
  logic       needs_wait;

  always_comb begin
    has_cmd1   = 1'b1;
    cmd1       = `CMD_READ_SETUP;
    addr_cnt   = 3'h0;
    has_cmd2   = 1'b0;
    cmd2       = `CMD_READ_CONFIRM;
    needs_wait = 1'b0;
    case (req_reg.op)
      OP_PAGE_READ: begin
        addr_cnt   = (req_reg.density == DENS_1G) ? `ADDR_CYC_SMALL
                                                  : `ADDR_CYC_LARGE; // R1
        has_cmd2   = 1'b1; // R10
        needs_wait = 1'b1;
      end
      OP_COL_CHANGE: begin
        cmd1     = `CMD_COL_SETUP; // R13
        addr_cnt = `ADDR_CYC_COLUMN;
        has_cmd2 = 1'b1;
        cmd2     = `CMD_COL_CONFIRM;
      end
      OP_CACHE_SEQ: begin
        cmd1       = `CMD_CACHE_NEXT; // R14
        needs_wait = 1'b1;
      end
      OP_CACHE_RAND: begin
        addr_cnt   = (req_reg.density == DENS_1G) ? `ADDR_CYC_SMALL
                                                  : `ADDR_CYC_LARGE; // R20
        has_cmd2   = 1'b1;
        cmd2       = `CMD_CACHE_NEXT;
        needs_wait = 1'b1;
      end
      OP_CACHE_LAST: begin
        cmd1       = `CMD_CACHE_LAST; // R17
        needs_wait = 1'b1;
      end
      OP_STATUS:    cmd1 = `CMD_STATUS;
      OP_RESUME:    cmd1 = `CMD_READ_SETUP; // R19
      default: begin
        // power-on preload: data is fetched without any command
        has_cmd1   = 1'b0; // R9
        needs_wait = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // address byte builder
  function automatic logic [7:0] addr_byte(input density_e d, input logic [12:0] c,
                                           input logic [16:0] r, input logic [2:0] i);
    logic [12:0] cs;
    cs = c;
    // spare access: clear the four bits below the top column bit
    if (d == DENS_4G && c[12]) begin
      cs[11:8] = 4'h0; // R6
    end else if (d != DENS_4G && c[11]) begin
      cs[10:7] = 4'h0; // R6
    end
    case (i)
      3'h0:    addr_byte = cs[7:0];
      3'h1:    addr_byte = (d == DENS_4G) ? {3'h0, cs[12:8]}          // R4
                                          : {4'h0, cs[11:8]};         // R2
      3'h2:    addr_byte = r[7:0];                                    // R3
      3'h3:    addr_byte = r[15:8];                                   // R3
      default: addr_byte = {7'h00, r[16]};                            // R3
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strobe phase divider, running only while the bus is being cycled
  assign bus_state = (state_reg == ST_CMD1) || (state_reg == ST_ADDR) ||
                     (state_reg == ST_CMD2) || (state_reg == ST_READ);
  assign tick      = bus_state && (div_reg == STROBE_CYC - 4'h1);
  assign cycle_end = tick && phase_reg;

  always_ff @(posedge clk_sys) begin
    if (rst || !bus_state || tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // phase 0 = strobe low, phase 1 = strobe high
  always_ff @(posedge clk_sys) begin
    if (rst || !bus_state) begin
      phase_reg <= 1'b0;
    end else if (tick) begin
      phase_reg <= ~phase_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (req_valid) state_next = ST_CMD1;
      ST_CMD1: begin
        if (!has_cmd1) begin
          state_next = ST_WAIT_WB;
        end else if (cycle_end) begin
          if (addr_cnt != 3'h0) begin
            state_next = ST_ADDR;
          end else if (needs_wait) begin
            state_next = ST_WAIT_WB;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_ADDR: if (cycle_end && byte_cnt_reg == 13'(addr_cnt - 3'h1)) state_next = ST_CMD2;
      ST_CMD2: if (cycle_end) state_next = needs_wait ? ST_WAIT_WB : ST_READ;
      // give the device time to pull the busy line low
      ST_WAIT_WB: if (wait_cnt_reg == BUSY_CYC - 6'h01) state_next = ST_WAIT_RDY;
      ST_WAIT_RDY: if (ready_busy) state_next = ST_READ; // R11
      ST_READ: begin
        if (req_reg.len == 13'h0000) begin
          state_next = ST_DONE;
        end else if (cycle_end && byte_cnt_reg == req_reg.len - 13'h0001) begin
          state_next = ST_DONE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request capture; status reads always return a single byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_reg <= '0;
    end else if (state_reg == ST_IDLE && req_valid) begin
      req_reg <= req;
      if (req.op == OP_STATUS) begin
        req_reg.len <= 13'h0001;
      end
    end
  end

  // byte counter, shared by address and data cycles
  always_ff @(posedge clk_sys) begin
    if (rst || state_reg != state_next) begin
      byte_cnt_reg <= 13'h0000;
    end else if (cycle_end) begin
      byte_cnt_reg <= byte_cnt_reg + 13'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || state_reg != ST_WAIT_WB) begin
      wait_cnt_reg <= 6'h00;
    end else begin
      wait_cnt_reg <= wait_cnt_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data capture: end of low phase, or next falling edge for fast cycles
  logic sample;
  assign sample = (state_reg == ST_READ) && (req_reg.len != 13'h0000) && tick &&
                  (phase_reg == EDO_MODE); // R12

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= sample;
      if (sample) begin
        rd_data <= io_in;
      end
    end
  end

  // status flags kept from the last status read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cache_ready_flag <= 1'b0;
      array_idle_flag  <= 1'b0;
    end else if (sample && req_reg.op == OP_STATUS) begin
      cache_ready_flag <= io_in[`SR_CACHE_READY_BIT]; // R18
      array_idle_flag  <= io_in[`SR_ARRAY_IDLE_BIT];  // R18
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_done <= 1'b0;
    end else begin
      op_done <= (state_reg == ST_DONE);
    end
  end

  assign req_ready = (state_reg == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // pin drive; write strobe rises halfway through each command or address cycle, at the end of its low phase
  // built in a local word so the zero default never glitches a strobe pin
  pin_out_s pin_drive;

  always_comb begin
    pin_drive               = '0;
    pin_drive.ce_n          = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
    pin_drive.we_n          = 1'b1;
    pin_drive.read_strobe_n = 1'b1;
    pin_drive.io_oe_n       = 1'b1;
    case (state_reg)
      ST_CMD1: begin
        pin_drive.cle     = has_cmd1;
        pin_drive.we_n    = ~has_cmd1 | phase_reg;
        pin_drive.io_out  = cmd1;
        pin_drive.io_oe_n = ~has_cmd1;
      end
      ST_ADDR: begin
        pin_drive.ale     = 1'b1;
        pin_drive.we_n    = phase_reg;
        pin_drive.io_out  = addr_byte(req_reg.density, req_reg.col, req_reg.row,
                                      byte_cnt_reg[2:0]); // R1
        pin_drive.io_oe_n = 1'b0;
      end
      ST_CMD2: begin
        pin_drive.cle     = 1'b1;
        pin_drive.we_n    = phase_reg;
        pin_drive.io_out  = cmd2; // R10
        pin_drive.io_oe_n = 1'b0;
      end
      ST_READ: begin
        pin_drive.read_strobe_n = phase_reg | (req_reg.len == 13'h0000);
      end
      default: pin_drive.io_oe_n = 1'b1;
    endcase
  end

  assign pins = pin_drive;

endmodule // nand_read_host

//--- dv/nand_dev_model.sv
// behavioural flash device answering the read host
`timescale 1ns/1ps
module nand_dev_model
  import nand_read_host_pkg::*;
(
  // host side
  input  wire logic     clk_sys,
  input  wire pin_out_s pins,
  // device answers
  output logic [7:0]    io_in,
  output logic          ready_busy
);
  logic [7:0] ab [5];
  int         na, nl, col, cp, np, rbc, arc, viol;
  logic       st;

  // page contents: a simple function of page and column
  function automatic logic [7:0] pat(int p, int c);
    return 8'(p * 7 + c);
  endfunction
  function automatic int row();
    return {15'h0, (na > 4) ? ab[4][0] : 1'b0, ab[3], ab[2]};
  endfunction
  function automatic int ca();
    return {19'h0, ab[1][4:0], ab[0]};
  endfunction

  // page zero sits in the cache after power up
  initial begin
    cp = 0; col = 0; na = 0; nl = 0; rbc = 0; arc = 0; viol = 0; st = 0;
    io_in = 8'h5a;
  end
  // open drain with pull-up: released means high
  assign ready_busy = (rbc == 0);

  // latch on the write strobe rise
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    if (pins.ale) begin
      ab[na % 5] = pins.io_out;
      na++;
    end else if (pins.cle) begin
      case (pins.io_out)
        8'h00: begin st = 0; na = 0; end
        8'h30: begin nl = na; cp = row(); col = ca(); np = cp + 1; rbc = 25; na = 0; end
        8'h31: begin
          cp = (na > 2) ? row() : np; np = cp + 1; col = 0; rbc = 15; arc = 80; na = 0;
        end
        8'h3f: begin cp = np; col = 0; rbc = 15; na = 0; end
        8'h05: na = 0;
        8'he0: begin col = ca(); na = 0; end
        8'h70: st = 1;
        default: na = 0;
      endcase
    end
  end

  // one byte per read strobe fall; status reads leave the column alone
  always @(negedge pins.read_strobe_n) begin
    if (!ready_busy && !st) viol++;
    io_in = st ? {1'b0, ready_busy, ready_busy && arc == 0, 5'h0} : pat(cp, col);
    if (!st) col++;
  end
  // released bus must not keep the last byte
  always @(posedge pins.read_strobe_n) #2 io_in = ~io_in;
  // busy timers; prefetch keeps the array busy past cache ready
  always @(posedge clk_sys) begin
    if (rbc > 0) rbc <= rbc - 1;
    if (arc > 0) arc <= arc - 1;
  end
endmodule // nand_dev_model

//--- dv/nand_read_host_props.sv
// port checker for the nand read host
`timescale 1ns/1ps
module nand_read_host_props
  import nand_read_host_pkg::*;
(
  // system
  input wire logic     clk_sys,
  input wire logic     rst,
  // user side
  input wire logic     req_ready,
  input wire logic     rd_valid,
  input wire logic     op_done,
  // flash pins
  input wire pin_out_s pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_idle: assert property (disable iff (1'b0)
    rst |=> req_ready && pins.ce_n && pins.we_n)
    else $error("not idle after reset");
  a_we_phase: assert property ($fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
    else $error("write strobe phase wrong");
  a_re_phase: assert property ($fell(pins.read_strobe_n) |-> !pins.read_strobe_n [*3]
    ##1 pins.read_strobe_n)
    else $error("read strobe phase wrong");
  a_latch_kind: assert property (!pins.we_n |-> !pins.io_oe_n && !pins.ce_n
    && (pins.cle != pins.ale))
    else $error("bad latch cycle");
  a_io_hold: assert property ($fell(pins.we_n) |-> ##1 $stable(pins.io_out) [*5])
    else $error("io moved in cycle");
  a_read_clean: assert property (!pins.read_strobe_n |-> pins.we_n && pins.io_oe_n
    && !pins.ce_n)
    else $error("read overlaps write");
  a_byte_out: assert property ($rose(pins.read_strobe_n) |-> ##[0:2] rd_valid)
    else $error("byte not delivered");
  a_busy_wait: assert property ($rose(pins.we_n) && pins.cle && pins.io_out == 8'h30
    |-> pins.read_strobe_n [*8])
    else $error("read before busy onset");
  a_done_pulse: assert property (op_done |-> req_ready ##1 !op_done)
    else $error("done not a pulse");

  c_done: cover property (op_done);
  c_byte: cover property (rd_valid);
  c_confirm: cover property ($rose(pins.we_n) && pins.cle && pins.io_out == 8'h31);
endmodule // nand_read_host_props
bind nand_read_host nand_read_host_props u_props (.clk_sys(clk_sys), .rst(rst),
  .req_ready(req_ready), .rd_valid(rd_valid), .op_done(op_done), .pins(pins));

//--- dv/nand_read_host_bench.sv
// testbench of the nand read host against a device model
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module nand_read_host_bench;
  import nand_read_host_pkg::*;
  logic       clk_sys = 0, rst = 1, req_valid = 0;
  req_s       req = '0;
  logic       req_ready, rd_valid, op_done, cr_flag, ai_flag, ready_busy;
  logic [7:0] rd_data, io_in;
  pin_out_s   pins;
  int         n_errors = 0, n_checks = 0, cyc = 0;
  logic [7:0] got [$];

  nand_read_host dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
    .op_done(op_done), .cache_ready_flag(cr_flag), .array_idle_flag(ai_flag),
    .pins(pins), .io_in(io_in), .ready_busy(ready_busy));
  nand_dev_model m (.clk_sys(clk_sys), .pins(pins), .io_in(io_in), .ready_busy(ready_busy));

  always #5 clk_sys = ~clk_sys;
  // collect bytes mid-cycle, away from the edge that updates them; cut a hang short
  always @(negedge clk_sys) begin
    cyc++;
    if (rd_valid) got.push_back(rd_data);
    if (cyc > 20000) begin n_errors++; results(); end
  end

  function automatic logic [7:0] pat(int p, int c);
    return 8'(p * 7 + c);
  endfunction
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one request, raised only while the host is idle, so it is taken at the next edge
  task op(op_e o, density_e d, logic [12:0] c, logic [16:0] r, logic [12:0] l);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (!req_ready) @(negedge clk_sys);
    got.delete();
    req_valid = 1;
    req = '{o, d, c, r, l};
    @(negedge clk_sys);
    req_valid = 0;
    while (op_done !== 1'b1 && k < 3000) begin @(negedge clk_sys); k++; end
    `CHK("done", 1'b1, op_done)
  endtask
  task chkd(int p, int c, int n);
    `CHK("count", n, got.size())
    for (int i = 0; i < n && i < got.size(); i++) `CHK("byte", pat(p, c + i), got[i])
  endtask

  task t_preload;
    op(OP_DATA_OUT, DENS_1G, 0, 0, 3);
    chkd(0, 0, 3);
    $display("preload done");
  endtask
  // every density, spare column so the host must clear the bits below the top one
  task t_addr;
    logic [12:0] ec;
    logic [16:0] r;
    for (int d = 0; d < 3; d++) begin
      ec = (d == 2) ? 13'h10a5 : 13'h0825;
      r = (d == 0) ? 17'h0abcd : 17'h1abcd;
      op(OP_PAGE_READ, density_e'(d), (d == 2) ? 13'h1fa5 : 13'h0fa5, r, 2);
      `CHK("n_addr", (d == 0) ? 4 : 5, m.nl)
      `CHK("a0", ec[7:0], m.ab[0])
      `CHK("a1", {3'h0, ec[12:8]}, m.ab[1])
      `CHK("a2", r[7:0], m.ab[2])
      `CHK("a3", r[15:8], m.ab[3])
      if (d > 0) `CHK("a4", 8'h01, m.ab[4])
      chkd(r, ec, 2);
    end
    op(OP_COL_CHANGE, DENS_4G, 13'h0010, 0, 2);
    chkd(17'h1abcd, 16, 2);
    $display("address done");
  endtask
  // last page of a block, so the next page crosses into the next block
  task t_seq;
    op(OP_PAGE_READ, DENS_2G, 0, 17'h0003f, 1);
    op(OP_CACHE_SEQ, DENS_2G, 0, 0, 2);
    chkd(64, 0, 2);
    op(OP_STATUS, DENS_2G, 0, 0, 1);
    `CHK("cache_rdy", 1'b1, cr_flag)
    `CHK("arr_idle", 1'b0, ai_flag)
    op(OP_RESUME, DENS_2G, 0, 0, 0);
    op(OP_DATA_OUT, DENS_2G, 0, 0, 2);
    chkd(64, 2, 2);
    op(OP_CACHE_LAST, DENS_2G, 0, 0, 2);
    chkd(65, 0, 2);
    op(OP_STATUS, DENS_2G, 0, 0, 1);
    `CHK("arr_idle", 1'b1, ai_flag)
    $display("sequential done");
  endtask
  task t_rand;
    op(OP_PAGE_READ, DENS_1G, 0, 17'h00100, 1);
    op(OP_CACHE_RAND, DENS_1G, 13'h0033, 17'h00207, 2);
    chkd(17'h00207, 0, 2);
    op(OP_COL_CHANGE, DENS_1G, 13'h0005, 0, 1);
    chkd(17'h00207, 5, 1);
    $display("random done");
  endtask

  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 0;
    `CHK("ready", 1'b1, req_ready)
    `CHK("ce_n", 1'b1, pins.ce_n)
    t_preload();
    t_addr();
    t_seq();
    t_rand();
    `CHK("early_read", 0, m.viol)
    results();
  end
endmodule // nand_read_host_bench
